//--- shared/spi_ctl_pkg.sv
// constants shared by the serial interface control logic and its link end
// assumes: a 25 MHz bus clock and a link clock that is the serial clock pin
package spi_ctl_pkg;

  // ****************************************************************
  // frame sizing
  // ****************************************************************
  localparam int         BYTE_BITS = 8;      // bits in one exchange
  localparam logic [3:0] HALF_LAST = 4'hF;   // 16 half periods = 8 clocks
  localparam logic [2:0] BIT_LAST  = 3'h7;   // last bit index on the link
  localparam logic [3:0] DIV_ONE   = 4'h1;   // base of the half period

  // ****************************************************************
  // values after system reset
  // ****************************************************************
  localparam logic       RST_TX_EMPTY = 1'b1;  // transmit register empty
  localparam logic       RST_MASTER   = 1'b1;  // master selected
  localparam logic       RST_CLEAR    = 1'b0;  // every other bit cleared
  localparam logic       RST_PIN_HI   = 1'b1;  // idle pin level / oe off
  localparam logic [7:0] RST_BYTE     = 8'h00; // data and shift registers

  // master engine states
  typedef enum logic {
    M_IDLE,
    M_RUN
  } mst_state_t;

endpackage : spi_ctl_pkg

//--- hw/spi_link_slave.sv
// slave shifter that runs on the serial clock pin
// assumes: idle high clock, data out on falling, sampled on rising edge;
// tx_word only changes while this end is cleared or between bytes
module spi_link_slave
  import spi_ctl_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       clr,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_word,
  output logic            miso,
  output logic [7:0]      rx_word,
  output logic            done_tgl
);

  logic [7:0] sh_r;   // shift register
  logic [2:0] cnt_r;  // state counter, bits taken so far
  logic [7:0] nxt;    // shift value after this edge

  // the first bit of a byte comes from the loaded word
  always_comb begin
    nxt = {(cnt_r == 3'h0) ? tx_word[6:0] : sh_r[6:0], mosi};
  end

  // ****************************************************************
  // capture on the rising edge; a high select ignores the clock
  // ****************************************************************
  always_ff @(posedge link_clk or posedge clr) begin
    if (clr) begin
      sh_r     <= RST_BYTE;
      cnt_r    <= 3'h0;
      rx_word  <= RST_BYTE;
      done_tgl <= RST_CLEAR;
    end else if (!ss_n) begin
      sh_r  <= nxt;
      cnt_r <= 3'(cnt_r + 3'h1);
      // eighth bit: hand the byte over by a toggle  [RQ21]
      if (cnt_r == BIT_LAST) begin
        rx_word  <= nxt;
        done_tgl <= !done_tgl;
      end
    end
  end

  // drive the next bit on the falling edge
  always_ff @(negedge link_clk or posedge clr) begin
    if (clr) begin
      miso <= RST_CLEAR;
    end else if (!ss_n) begin
      miso <= (cnt_r == 3'h0) ? tx_word[7] : sh_r[7];
    end
  end

endmodule : spi_link_slave

//--- hw/spi_irq_ctl.sv
// flags, interrupt requests, partial reset, low power, break protection
// and pin ownership of a byte-wide serial interface
// assumes: control strobes are one-cycle pulses on ref_clk; pins and the
// link clock arrive from outside; select and master in are synchronised here, the link clock runs the link end directly
// Contract
// RQ1 - tx request needs empty, enable, module on
// RQ2 - rx request needs full and enable only
// RQ3 - error enable gates overrun and fault together
// RQ4 - fault flag blocked while detection disabled
// RQ5 - status read then data read clears full
// RQ6 - only data write clears transmit empty
// RQ7 - byte into receive register sets full
// RQ8 - byte into shift register sets empty
// RQ9 - system reset restores every bit
// RQ10 - module off: empty set, abort, release pins
// RQ11 - partial reset keeps control bits and flags
// RQ12 - master fault clears module on
// RQ13 - wait: runs, no access, requests wake
// RQ14 - stop: halts, keeps registers
// RQ15 - reset out of stop aborts and resets
// RQ16 - break without permit protects flags
// RQ17 - break with permit lets flags clear
// RQ18 - break without permit ignores data write
// RQ19 - slave out only as selected slave
// RQ20 - enabled module owns data and clock pins
// RQ21 - master drives clock, eight clocks per byte
// RQ22 - wired-or makes master out open drain
// RQ23 - fault on select against the mode
// RQ24 - overrun on unread byte, new byte dropped
// RQ25 - requests are levels, drop one cycle late
module spi_irq_ctl
  import spi_ctl_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       link_clk,
  input  wire logic       ss_n_in,
  input  wire logic       mosi_in,
  input  wire logic       miso_in,
  input  wire logic       ctrl_wr,
  input  wire logic       ctrl_module_on,
  input  wire logic       ctrl_master,
  input  wire logic       ctrl_tx_ie,
  input  wire logic       ctrl_rx_ie,
  input  wire logic       ctrl_wired_or,
  input  wire logic       stat_wr,
  input  wire logic       stat_err_ie,
  input  wire logic       stat_fault_en,
  input  wire logic       stat_baud_hi,
  input  wire logic       stat_baud_lo,
  input  wire logic       stat_rd,
  input  wire logic       data_rd,
  input  wire logic       data_wr,
  input  wire logic [7:0] data_wdata,
  input  wire logic       wait_mode,
  input  wire logic       stop_mode,
  input  wire logic       break_state,
  input  wire logic       break_clear_permit,
  output logic            sclk_out,
  output logic            sclk_oe_n,
  output logic            mosi_out,
  output logic            mosi_oe_n,
  output logic            miso_out,
  output logic            miso_oe_n,
  output logic            port_owned,
  output logic            tx_empty_flag,
  output logic            rx_full_flag,
  output logic            overrun_flag,
  output logic            mode_fault_flag,
  output logic [7:0]      rx_data,
  output logic            irq_tx,
  output logic            irq_rx_err,
  output logic            wake_req
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic       module_on_r, master_r, wired_or_r;  // control bits
  logic       tx_ie_r, rx_ie_r, err_ie_r, fault_en_r;
  logic       baud_hi_r, baud_lo_r;               // half period select
  logic       rx_arm_r, ov_arm_r, mf_arm_r;       // first clearing step
  logic [7:0] tx_buf_r;                           // transmit register
  logic [7:0] tx_word_r;                          // slave load word
  logic       slave_busy_r;                       // slave byte under way
  logic       link_clr_r;                         // holds link end clear
  logic       ss_m_r, ss_s_r, ss_d_r;             // select synchroniser
  logic       miso_m_r, miso_s_r;                 // master in synchroniser
  logic       dn_m_r, dn_s_r, dn_d_r;             // done toggle crossing
  mst_state_t mst_st_r;                           // master engine state
  logic [3:0] half_r;                             // master half periods
  logic [2:0] div_r;                              // half period divider
  logic [7:0] mst_sh_r;                           // master shift register
  logic [7:0] mst_rx_r;                           // master receive shift
  logic [1:0] rise_dly_r;                         // rise strobe delay line
  logic [1:0] last_dly_r;                         // last rise delay line
  logic [7:0] link_rx;                            // byte from link end
  logic       link_tgl;                           // link done toggle
  logic       acc, lock;                          // access and protection
  logic       wr_ok, rd_ok, st_ok, ctrl_ok;       // accepted accesses
  logic       load_go, mst_done, slv_done;        // transfer events
  logic       byte_done, mf_event, mst_rise, mst_last;
  logic [7:0] byte_word;
  logic [2:0] div_lim;
  logic       tx_irq_nxt, rxe_irq_nxt;

  // ****************************************************************
  // access qualification and events
  // ****************************************************************
  always_comb begin
    acc       = !wait_mode;                          // [RQ13]
    lock      = break_state && !break_clear_permit;  // [RQ16] [RQ17]
    wr_ok     = data_wr && acc && !lock;             // [RQ18]
    rd_ok     = data_rd && acc && !lock;
    st_ok     = stat_rd && acc && !lock;
    ctrl_ok   = ctrl_wr && acc;
    div_lim   = 3'((DIV_ONE << {baud_hi_r, baud_lo_r}) - DIV_ONE);
    // stop halts all loads  [RQ14]
    load_go   = !tx_empty_flag && module_on_r && !stop_mode &&
                (master_r ? (mst_st_r == M_IDLE) : !slave_busy_r);
    // a rise of the master clock, and the last rise of the byte
    mst_rise  = module_on_r && master_r && !stop_mode &&
                (mst_st_r == M_RUN) && (div_r == div_lim) && half_r[0];
    mst_last  = mst_rise && (half_r == HALF_LAST);
    // the byte is whole once its last bit is through the synchroniser
    mst_done  = last_dly_r[1] && module_on_r && master_r;
    slv_done  = (dn_s_r ^ dn_d_r) && !link_clr_r;
    byte_done = mst_done || slv_done;
    byte_word = master_r ? {mst_rx_r[6:0], miso_s_r} : link_rx;
    // fault detection gated by its enable  [RQ4] [RQ23]
    mf_event  = fault_en_r && module_on_r &&
                (master_r ? !ss_s_r
                          : (slave_busy_r && ss_s_r && !ss_d_r));
    tx_irq_nxt  = tx_empty_flag && tx_ie_r && module_on_r;  // [RQ1]
    rxe_irq_nxt = (rx_full_flag && rx_ie_r) ||              // [RQ2]
                  (err_ie_r && (overrun_flag || mode_fault_flag)); // [RQ3]
  end

  // ****************************************************************
  // pin synchronisers and the done crossing
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ss_m_r   <= RST_PIN_HI;
      ss_s_r   <= RST_PIN_HI;
      ss_d_r   <= RST_PIN_HI;
      miso_m_r <= RST_CLEAR;
      miso_s_r <= RST_CLEAR;
      dn_m_r   <= RST_CLEAR;
      dn_s_r   <= RST_CLEAR;
      dn_d_r   <= RST_CLEAR;
    end else begin
      ss_m_r   <= ss_n_in;
      ss_s_r   <= ss_m_r;
      ss_d_r   <= ss_s_r;
      miso_m_r <= miso_in;
      miso_s_r <= miso_m_r;
      dn_m_r   <= link_tgl;
      dn_s_r   <= dn_m_r;
      dn_d_r   <= dn_s_r;
    end
  end

  // ****************************************************************
  // control bits: kept through partial reset
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin  // [RQ9] [RQ15]
      module_on_r <= RST_CLEAR;
      master_r    <= RST_MASTER;
      wired_or_r  <= RST_CLEAR;
      tx_ie_r     <= RST_CLEAR;
      rx_ie_r     <= RST_CLEAR;
      err_ie_r    <= RST_CLEAR;
      fault_en_r  <= RST_CLEAR;
      baud_hi_r   <= RST_CLEAR;
      baud_lo_r   <= RST_CLEAR;
    end else begin
      // only system reset, or a master fault for module on, clears these  [RQ11]
      if (ctrl_ok) begin
        master_r   <= ctrl_master;
        wired_or_r <= ctrl_wired_or;
        tx_ie_r    <= ctrl_tx_ie;
        rx_ie_r    <= ctrl_rx_ie;
      end
      if (mf_event && master_r) begin
        module_on_r <= RST_CLEAR;  // master fault disables  [RQ12]
      end else if (ctrl_ok) begin
        module_on_r <= ctrl_module_on;
      end
      if (stat_wr && acc) begin
        err_ie_r   <= stat_err_ie;
        fault_en_r <= stat_fault_en;
        baud_hi_r  <= stat_baud_hi;
        baud_lo_r  <= stat_baud_lo;
      end
    end
  end

  // ****************************************************************
  // transmit register and empty flag
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_empty_flag <= RST_TX_EMPTY;
      tx_buf_r      <= RST_BYTE;
      tx_word_r     <= RST_BYTE;
    end else begin
      if (wr_ok) begin  // only a data write clears it  [RQ6]
        tx_empty_flag <= RST_CLEAR;
        tx_buf_r      <= data_wdata;
      end
      // load into the shift register, or module off: set wins
      if (load_go || !module_on_r) begin  // [RQ8] [RQ10]
        tx_empty_flag <= RST_TX_EMPTY;
      end
      if (!module_on_r) begin
        tx_word_r <= RST_BYTE;  // shift contents cleared  [RQ10]
      end else if (load_go && !master_r) begin
        tx_word_r <= tx_buf_r;
      end
    end
  end

  // ****************************************************************
  // receive register, full and overrun flags
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_full_flag <= RST_CLEAR;
      overrun_flag <= RST_CLEAR;
      rx_data      <= RST_BYTE;
    end else begin
      // second step of the two-step clear  [RQ5] [RQ16] [RQ17]
      if (rd_ok && rx_arm_r) begin
        rx_full_flag <= RST_CLEAR;
      end
      if (rd_ok && ov_arm_r) begin
        overrun_flag <= RST_CLEAR;
      end
      // events after the clears so that a set wins
      if (byte_done && !overrun_flag) begin
        if (!rx_full_flag) begin
          rx_full_flag <= 1'b1;  // [RQ7]
          rx_data      <= byte_word;
        end else begin
          overrun_flag <= 1'b1;  // new byte dropped  [RQ24]
        end
      end
    end
  end

  // ****************************************************************
  // mode fault flag
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_fault_flag <= RST_CLEAR;
    end else if (mf_event) begin
      mode_fault_flag <= 1'b1;  // [RQ23]
    end else if (ctrl_ok && !lock && mf_arm_r) begin
      mode_fault_flag <= RST_CLEAR;  // [RQ16]
    end
  end

  // first clearing step; held through a protected break
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_arm_r <= RST_CLEAR;
      ov_arm_r <= RST_CLEAR;
      mf_arm_r <= RST_CLEAR;
    end else if (st_ok) begin  // [RQ5]
      rx_arm_r <= rx_full_flag;
      ov_arm_r <= overrun_flag;
      mf_arm_r <= mode_fault_flag;
    end else if (rd_ok) begin
      rx_arm_r <= RST_CLEAR;
      ov_arm_r <= RST_CLEAR;
    end else if (ctrl_ok && !lock) begin
      mf_arm_r <= RST_CLEAR;
    end
  end

  // ****************************************************************
  // slave tracking and link end control
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slave_busy_r <= RST_CLEAR;
      link_clr_r   <= RST_PIN_HI;
    end else begin
      // off, master or stopped holds the link end cleared  [RQ10] [RQ14]
      link_clr_r <= !module_on_r || master_r || stop_mode;
      if (!module_on_r || master_r) begin
        slave_busy_r <= RST_CLEAR;
      end else if (!ss_s_r && ss_d_r) begin
        slave_busy_r <= 1'b1;
      end else if (slv_done || (ss_s_r && !ss_d_r)) begin
        slave_busy_r <= RST_CLEAR;
      end
    end
  end

  spi_link_slave u_link (
    .link_clk (link_clk),
    .clr      (link_clr_r),
    .ss_n     (ss_n_in),
    .mosi     (mosi_in),
    .tx_word  (tx_word_r),
    .miso     (miso_out),
    .rx_word  (link_rx),
    .done_tgl (link_tgl)
  );

  // ****************************************************************
  // master engine: eight clocks per byte, idle high
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mst_st_r  <= M_IDLE;
      half_r    <= 4'h0;
      div_r     <= 3'h0;
      mst_sh_r  <= RST_BYTE;
      sclk_out  <= RST_PIN_HI;
      mosi_out  <= RST_PIN_HI;
      mosi_oe_n <= RST_PIN_HI;
    end else if (!module_on_r || !master_r) begin
      // partial reset aborts the byte and frees the pins  [RQ10]
      mst_st_r  <= M_IDLE;
      half_r    <= 4'h0;
      div_r     <= 3'h0;
      mst_sh_r  <= RST_BYTE;
      sclk_out  <= RST_PIN_HI;
      mosi_out  <= RST_PIN_HI;
      mosi_oe_n <= RST_PIN_HI;
    end else if (!stop_mode) begin  // stop freezes  [RQ14]
      unique case (mst_st_r)
        M_IDLE: begin
          // open drain releases a high bit  [RQ22]
          mosi_oe_n <= wired_or_r && mosi_out;
          if (load_go) begin
            mst_sh_r <= tx_buf_r;
            half_r   <= 4'h0;
            div_r    <= 3'h0;
            mst_st_r <= M_RUN;
          end
        end
        M_RUN: begin
          if (div_r != div_lim) begin
            div_r <= 3'(div_r + 3'h1);
          end else begin
            div_r  <= 3'h0;
            half_r <= 4'(half_r + 4'h1);
            if (!half_r[0]) begin  // falling edge drives  [RQ21]
              sclk_out  <= 1'b0;
              mosi_out  <= mst_sh_r[7];
              mosi_oe_n <= wired_or_r && mst_sh_r[7];  // [RQ22]
            end else begin  // rising edge samples
              sclk_out <= RST_PIN_HI;
              mst_sh_r <= {mst_sh_r[6:0], RST_CLEAR};
              if (half_r == HALF_LAST) begin
                mst_st_r <= M_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // master capture: the synchroniser delays the pin by two cycles, so
  // each rise is taken two cycles late, reading the level it met
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rise_dly_r <= 2'h0;
      last_dly_r <= 2'h0;
      mst_rx_r   <= RST_BYTE;
    end else if (!module_on_r || !master_r) begin
      // abort drops bits still on their way  [RQ10]
      rise_dly_r <= 2'h0;
      last_dly_r <= 2'h0;
      mst_rx_r   <= RST_BYTE;
    end else begin
      rise_dly_r <= {rise_dly_r[0], mst_rise};
      last_dly_r <= {last_dly_r[0], mst_last};
      if (rise_dly_r[1]) begin  // [RQ21]
        mst_rx_r <= {mst_rx_r[6:0], miso_s_r};
      end
    end
  end

  // ****************************************************************
  // pin ownership and requests
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_owned <= RST_CLEAR;
      sclk_oe_n  <= RST_PIN_HI;
      miso_oe_n  <= RST_PIN_HI;
    end else begin
      port_owned <= module_on_r;                   // [RQ20] [RQ10]
      sclk_oe_n  <= !(module_on_r && master_r);    // [RQ21]
      miso_oe_n  <= !(module_on_r && !master_r && !ss_s_r);  // [RQ19]
    end
  end

  // level requests, one cycle behind their causes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_tx     <= RST_CLEAR;
      irq_rx_err <= RST_CLEAR;
      wake_req   <= RST_CLEAR;
    end else begin
      irq_tx     <= tx_irq_nxt;   // [RQ25]
      irq_rx_err <= rxe_irq_nxt;  // [RQ25]
      wake_req   <= wait_mode && (tx_irq_nxt || rxe_irq_nxt);  // [RQ13]
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  tx_req_off_a: assert property (!module_on_r |=> !irq_tx) // [RQ1]
    else $error("tx request while module off");
  rx_req_a: assert property ( // [RQ2]
    rx_full_flag && rx_ie_r && !module_on_r |=> irq_rx_err)
    else $error("rx request missing");
  err_req_a: assert property ( // [RQ3]
    err_ie_r && (overrun_flag || mode_fault_flag) |=> irq_rx_err)
    else $error("error request missing");
  fault_block_a: assert property ( // [RQ4]
    !fault_en_r && !mode_fault_flag |=> !mode_fault_flag)
    else $error("fault flag set while disabled");
  empty_clear_a: assert property ( // [RQ6]
    $fell(tx_empty_flag) |-> $past(data_wr))
    else $error("empty cleared without data write");
  off_release_a: assert property ( // [RQ10]
    !module_on_r |=> tx_empty_flag && !port_owned && sclk_oe_n)
    else $error("module off did not release");
  master_fault_a: assert property ( // [RQ12]
    $rose(mode_fault_flag) && $past(master_r) |-> !module_on_r)
    else $error("master fault left module on");
  wait_deny_a: assert property ( // [RQ13]
    wait_mode && data_wr |=> !$fell(tx_empty_flag))
    else $error("write accepted in wait");
  break_hold_a: assert property ( // [RQ16]
    lock |=> !$fell(rx_full_flag) && !$fell(mode_fault_flag))
    else $error("flag cleared in protected break");
  break_write_a: assert property ( // [RQ18]
    lock && data_wr |=> !$fell(tx_empty_flag))
    else $error("write took effect in break");
  slave_out_a: assert property (master_r |=> miso_oe_n) // [RQ19]
    else $error("master drove slave out");

  rx_full_c: cover property ($rose(rx_full_flag));
  overrun_c: cover property ($rose(overrun_flag));
  fault_c: cover property ($rose(mode_fault_flag));
  tx_req_c: cover property ($rose(irq_tx));

endmodule : spi_irq_ctl

//--- sim/spi_peer.sv
// far side serial device: slave to the design master, master to its slave
// assumes: idle high clock, data changes on fall, sampled on rise
module spi_peer (
  input  wire logic sclk,    // design master clock level
  input  wire logic act,     // design master drives its clock
  input  wire logic mosi,    // master out line level
  input  wire logic miso_s,  // slave out line level
  output logic      miso,    // our slave out to the design
  output logic      lclk,    // link clock we make as master
  output logic      mdrv,    // our master out
  output logic [7:0] got     // last byte received
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'hA5;  // first reply, then echo
  int         n  = 0;      // bits seen as slave
  initial begin
    miso = 1'b1;
    lclk = 1'b1;
    mdrv = 1'b1;
    got  = 8'h00;
  end
  // shift out on fall, msb first
  always @(negedge sclk) begin
    if (act) begin
      miso = sh[7];
      sh   = {sh[6:0], 1'b0};
    end
  end
  // sample on rise; released line flips after the byte
  always @(posedge sclk) begin
    if (act) begin
      got = {got[6:0], mosi};
      n++;
      if (n % 8 == 0) begin
        sh = got;
        #2 miso = ~miso;
      end
    end
  end
  // one byte as master, 6 ns link period, eight clocks
  task send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      lclk = 1'b0;
      mdrv = b[i];
      #3 lclk = 1'b1;
      got = {got[6:0], miso_s};
      #3;
    end
    mdrv = ~mdrv;
  endtask : send
endmodule : spi_peer

//--- sim/tb.sv
// self-checking bench of the serial interface control block
// assumes: the peer model of the far side; strobes 1 ns after edges
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_ctl_pkg::*;
  logic ref_clk = 0, rst = 1, ss_n = 1, brk = 0, pmt = 0, wt = 0;
  logic stop_mode = 0;
  logic [4:0] st = 0, cb = 0;  // strobes, control bits
  logic [3:0] sb = 0;          // status control bits
  logic [7:0] wd = 0;
  logic sclk, sclk_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, owned;
  logic txe, rxf, ovr, mdf, irq_tx, irq_re, wake, lclk, mdrv, pmiso;
  logic [7:0] rxd;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  spi_irq_ctl dut (.ref_clk(ref_clk), .rst(rst), .link_clk(lclk),
    .ss_n_in(ss_n), .mosi_in(mdrv), .miso_in(pmiso), .ctrl_wr(st[4]),
    .ctrl_module_on(cb[4]), .ctrl_master(cb[3]), .ctrl_tx_ie(cb[2]),
    .ctrl_rx_ie(cb[1]), .ctrl_wired_or(cb[0]), .stat_wr(st[3]),
    .stat_err_ie(sb[3]), .stat_fault_en(sb[2]), .stat_baud_hi(sb[1]),
    .stat_baud_lo(sb[0]), .stat_rd(st[2]), .data_rd(st[1]),
    .data_wr(st[0]), .data_wdata(wd), .wait_mode(wt),
    .stop_mode(stop_mode), .break_state(brk), .break_clear_permit(pmt),
    .sclk_out(sclk), .sclk_oe_n(sclk_oe_n), .mosi_out(mosi),
    .mosi_oe_n(mosi_oe_n), .miso_out(miso), .miso_oe_n(miso_oe_n),
    .port_owned(owned), .tx_empty_flag(txe), .rx_full_flag(rxf),
    .overrun_flag(ovr), .mode_fault_flag(mdf), .rx_data(rxd),
    .irq_tx(irq_tx), .irq_rx_err(irq_re), .wake_req(wake));
  // pulled-up lines take the driver's level only while enabled
  spi_peer peer (.sclk(sclk), .act(!sclk_oe_n),
    .mosi(mosi_oe_n ? 1'b1 : mosi), .miso_s(miso_oe_n ? 1'b1 : miso),
    .miso(pmiso), .lclk(lclk), .mdrv(mdrv), .got());
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  task pulse(input logic [4:0] v);
    st = v;
    tick(1);
    st = 5'h00;
  endtask : pulse
  task chk(input logic [15:0] s, input logic [15:0] e, input string nm);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task close_out();
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    tick(8);
    rst = 0;
    chk({txe, rxf, ovr, mdf, irq_tx, irq_re, owned}, 8'h40, "rst");
    cb = 5'h1E;
    pulse(5'h10);
    tick(1);
    chk({owned, sclk_oe_n, irq_tx}, 8'h05, "own");
    wd = 8'h3C;
    pulse(5'h01);
    chk(txe, 0, "txe wr");
    for (int i = 0; i < 200 && rxf !== 1'b1; i++) tick(1);
    tick(2);
    chk(rxd, 8'hA5, "rxd");
    chk(peer.got, 8'h3C, "sent");
    chk({txe, irq_re}, 8'h03, "txe irq");
    sb = 4'h8;
    pulse(5'h08);
    wd = 8'h81;
    pulse(5'h01);
    tick(40);
    chk({ovr, rxd}, 9'h1A5, "ovr");
    cb = 5'h1C;
    pulse(5'h10);
    tick(1);
    chk(irq_re, 1, "err irq");
    brk = 1;
    pulse(5'h04);
    pulse(5'h02);
    pulse(5'h01);
    chk({ovr, rxf, txe}, 8'h07, "brk");
    pmt = 1;
    pulse(5'h04);
    pulse(5'h02);
    brk = 0;
    pmt = 0;
    tick(2);
    chk({ovr, rxf, irq_re}, 8'h00, "brk clr");
    ss_n = 0;
    tick(4);
    chk(mdf, 0, "no fault");
    ss_n = 1;
    tick(3);
    sb = 4'hC;
    pulse(5'h08);
    chk(mdf, 0, "fault idle");
    ss_n = 0;
    tick(4);
    chk({mdf, owned, sclk_oe_n, txe}, 8'h0B, "fault");
    chk(irq_re, 1, "fault irq");
    ss_n = 1;
    sb = 4'h8;
    pulse(5'h08);
    tick(3);
    pulse(5'h04);
    cb = 5'h16;
    pulse(5'h10);
    wt = 1;
    pulse(5'h01);
    chk(txe, 1, "wait wr");
    tick(1);
    chk(wake, 1, "wake");
    wt = 0;
    wd = 8'h5A;
    pulse(5'h01);
    tick(2);
    ss_n = 0;
    tick(3);
    chk(miso_oe_n, 0, "miso on");
    peer.send(8'hC3);
    tick(6);
    chk({rxf, rxd}, 9'h1C3, "slv rx");
    chk(peer.got, 8'h5A, "slv tx");
    ss_n = 1;
    tick(3);
    chk(miso_oe_n, 1, "miso off");
    pulse(5'h04);
    pulse(5'h02);
    chk(rxf, 0, "rx clr");
    cb = 5'h19;
    pulse(5'h10);
    tick(1);
    stop_mode = 1;
    wd = 8'h96;
    pulse(5'h01);
    tick(4);
    chk({txe, sclk, mosi_oe_n}, 8'h03, "stop");
    rst = 1;
    tick(2);
    rst = 0;
    stop_mode = 0;
    chk({txe, owned, mdf, sclk_oe_n}, 8'h09, "stop rst");
    close_out();
  end
endmodule : tb
